// file: tvic_pkg.sv
package tvic_pkg;

  // ----------------------------------------
  // Sources and ordering
  // ----------------------------------------
  localparam int NSRC = 18;
  localparam int IDXW = 5;
  localparam int SRC_TIMER2 = 5;
  localparam int SRC_SPI = 6;
  localparam int SRC_LIN = 14;
  localparam logic [17:0] HWCLR_SET = 18'h1_000f;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_MASK = 8'ha8;
  localparam logic [7:0] ADDR_LVL0 = 8'hb8;
  localparam logic [7:0] ADDR_MASK1 = 8'he6;
  localparam logic [7:0] ADDR_LVL1 = 8'hf6;
  localparam logic [7:0] ADDR_MASK2 = 8'he7;
  localparam logic [7:0] ADDR_LVL2 = 8'hf7;
  localparam logic [7:0] ADDR_LIN_CTRL = 8'hc9;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int GATE_BIT = 7;
  localparam int LIN_CLR_BIT = 3;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [6:0] LVL0_RST = 7'h00;
  localparam logic [7:0] EXT_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // ----------------------------------------
  // Vectors and timing
  // ----------------------------------------
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int DETECT_CYC = 1;
  localparam int CALL_CYC = 4;
  localparam int MIN_LAT = DETECT_CYC + CALL_CYC;
  localparam int RETURN_FROM_IRQ_INSTRUCTION_CYC = 5;
  localparam int DIV_CYC = 8;
  localparam int MAX_LAT = DETECT_CYC + RETURN_FROM_IRQ_INSTRUCTION_CYC + DIV_CYC + CALL_CYC;

  typedef enum logic [1:0] {
    SVC_IDLE,
    SVC_LOW,
    SVC_HIGH,
    SVC_HIGH_OVER_LOW
  } tvic_svc_t;

endpackage

// file: tvic_flags.sv
`timescale 1ns/1ps
module tvic_flags (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [17:0] src_set,
  input wire logic [17:0] sw_set,
  input wire logic [17:0] sw_clr,
  input wire logic [17:0] hw_clr,
  output logic [17:0] pend
);

  genvar i;
  // (RL1) One flag per source
  generate
    for (i = 0; i < tvic_pkg::NSRC; i++) begin : g_flag
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          pend[i] <= 1'b0;
        end else if (src_set[i] || sw_set[i]) begin
          pend[i] <= 1'b1;
        end else if (sw_clr[i] || hw_clr[i]) begin
          pend[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// file: tvic_arb.sv
`timescale 1ns/1ps
module tvic_arb (
  input wire logic [17:0] req,
  input wire logic [17:0] lvl,
  output logic any,
  output logic win_high,
  output logic [4:0] win_idx
);

  logic [17:0] hi;
  logic [17:0] pool;

  always_comb begin
    hi = req & lvl;
    win_high = |hi;
    pool = win_high ? hi : req;
    any = |req;
    win_idx = '0;
    // Lowest index wins inside the chosen level
    for (int k = tvic_pkg::NSRC - 1; k >= 0; k--) begin
      if (pool[k]) begin
        win_idx = k[4:0];
      end
    end
  end

endmodule

// file: tvic_top.sv
`timescale 1ns/1ps
// How it works
// (RL1) Eighteen sources, each with its own vector, besides reset.
// (RL2) Software setting a pending flag raises a request like hardware.
// (RL3) Vector is 0x0003 plus eight per order index, up to 0x008B.
// (RL4) High level preempts low service; nothing preempts high service.
// (RL5) All level-select bits are zero after reset.
// (RL6) Simultaneous requests: high level first, then lowest index.
// (RL7) Enabled pending requests are sampled and arbitrated every clock.
// (RL8) Request is raised one clock after detection; call takes four.
// (RL9) After return, one more instruction completes before next call.
// (RL10) Worst latency eighteen clocks: detect, return, divide, call.
// (RL11) Equal or higher level service holds new requests until return.
// (RL12) Bit 7 of mask register gates all sources globally.
// (RL13) Mask bits 6..0: SPI, timer2, UART, timer1, ext1, timer0, ext0.
// (RL14) Timer2 mask gates both overflows; SPI mask gates four flags.
// (RL15) Mask register at 0xA8, bit-addressable, all pages, resets zero.
// (RL16) One level bit per source across base and extended registers.
// (RL17) LIN flag cleared only by writing one to LIN control bit 3.
// (RL18) Flags set regardless of enables; disabled flags make no request.
// (RL19) Flag still set after return re-requests after next instruction.
// (RL20) Software clears non-self-clearing flags before returning.
// (RL21) Ext0, ext1, timer0, timer1 and CAN flags clear on the call.
// (RL22) Request strobe with vector to CPU; CPU acknowledges the call.
module tvic_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic sfr_bit_wr,
  input wire logic [7:0] sfr_bit_addr,
  input wire logic sfr_bit_val,
  output logic [7:0] sfr_rdata,
  input wire logic [17:0] src_event,
  input wire logic [17:0] sw_flag_set,
  input wire logic [17:0] sw_flag_clr,
  input wire logic timer2_high_overflow_flag,
  input wire logic timer2_low_overflow_flag,
  input wire logic [3:0] serial_periph_flags,
  output logic [17:0] pend_flags,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic irq_high,
  input wire logic cpu_ack,
  input wire logic cpu_return_from_irq_instruction,
  input wire logic cpu_insn_done
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] mask_r;
  logic [6:0] lvl0_r;
  logic [7:0] mask1_r;
  logic [7:0] lvl1_r;
  logic [7:0] mask2_r;
  logic [7:0] lvl2_r;
  logic [7:0] sfr_rdata_r;
  logic irq_req_r;
  logic irq_high_r;
  logic [4:0] idx_r;
  logic [15:0] irq_vector_r;
  logic hold_r;
  tvic_pkg::tvic_svc_t svc_r;
  tvic_pkg::tvic_svc_t svc_nxt;

  logic global_irq_gate;
  logic [17:0] en;
  logic [17:0] lvl;
  logic [17:0] req_raw;
  logic [17:0] req_en;
  logic [17:0] hw_clr;
  logic [17:0] sw_clr;
  logic [17:0] pend;
  logic lin_clr;
  logic any;
  logic win_high;
  logic [4:0] win_idx;
  logic elig;
  logic taken;

  function automatic logic [7:0] sfr_upd(input logic [7:0] cur,
                                         input logic [7:0] a);
    logic [7:0] v;
    v = cur;
    if (sfr_wr && sfr_addr == a) begin
      v = sfr_wdata;
    end
    if (sfr_bit_wr && {sfr_bit_addr[7:3], 3'b000} == a) begin
      v[sfr_bit_addr[2:0]] = sfr_bit_val;
    end
    return v;
  endfunction

  // (RL15) Mask register, byte and bit access
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask_r <= tvic_pkg::MASK_RST;
    end else begin
      mask_r <= sfr_upd(mask_r, tvic_pkg::ADDR_MASK);
    end
  end

  // (RL5) Level bits clear at reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lvl0_r <= tvic_pkg::LVL0_RST;
      lvl1_r <= tvic_pkg::EXT_RST;
      lvl2_r <= tvic_pkg::EXT_RST;
    end else begin
      lvl0_r <= 7'(sfr_upd({1'b1, lvl0_r}, tvic_pkg::ADDR_LVL0));
      lvl1_r <= sfr_upd(lvl1_r, tvic_pkg::ADDR_LVL1);
      lvl2_r <= sfr_upd(lvl2_r, tvic_pkg::ADDR_LVL2);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask1_r <= tvic_pkg::EXT_RST;
      mask2_r <= tvic_pkg::EXT_RST;
    end else begin
      mask1_r <= sfr_upd(mask1_r, tvic_pkg::ADDR_MASK1);
      mask2_r <= sfr_upd(mask2_r, tvic_pkg::ADDR_MASK2);
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata_r <= tvic_pkg::UNMAPPED_RD;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        tvic_pkg::ADDR_MASK: sfr_rdata_r <= mask_r;
        tvic_pkg::ADDR_LVL0: sfr_rdata_r <= {1'b1, lvl0_r};
        tvic_pkg::ADDR_MASK1: sfr_rdata_r <= mask1_r;
        tvic_pkg::ADDR_LVL1: sfr_rdata_r <= lvl1_r;
        tvic_pkg::ADDR_MASK2: sfr_rdata_r <= mask2_r;
        tvic_pkg::ADDR_LVL2: sfr_rdata_r <= lvl2_r;
        default: sfr_rdata_r <= tvic_pkg::UNMAPPED_RD;
      endcase
    end
  end

  // ----------------------------------------
  // Enables, levels and requests
  // ----------------------------------------
  always_comb begin
    global_irq_gate = mask_r[tvic_pkg::GATE_BIT];
    // (RL13) Base mask bits map sources 0..6
    en = {mask2_r[2:0], mask1_r, mask_r[6:0]};
    // (RL16) One level bit per source
    lvl = {lvl2_r[2:0], lvl1_r, lvl0_r};
    req_raw = pend;
    // (RL14) Grouped flags share one mask bit
    req_raw[tvic_pkg::SRC_TIMER2] = pend[tvic_pkg::SRC_TIMER2] |
      timer2_high_overflow_flag | timer2_low_overflow_flag;
    req_raw[tvic_pkg::SRC_SPI] = pend[tvic_pkg::SRC_SPI] |
      (|serial_periph_flags);
    // (RL12) Global gate over every mask
    // (RL18) Disabled flags never request
    req_en = req_raw & en & {18{global_irq_gate}};
  end

  // (RL17) LIN clear only through its control bit
  assign lin_clr = sfr_wr && sfr_addr == tvic_pkg::ADDR_LIN_CTRL &&
    sfr_wdata[tvic_pkg::LIN_CLR_BIT];

  assign taken = irq_req_r && cpu_ack;

  // (RL21) Self-clearing flags drop on the call
  always_comb begin
    hw_clr = '0;
    if (taken) begin
      hw_clr[idx_r] = 1'b1;
    end
    hw_clr = hw_clr & tvic_pkg::HWCLR_SET;
    hw_clr[tvic_pkg::SRC_LIN] = lin_clr;
    sw_clr = sw_flag_clr;
    sw_clr[tvic_pkg::SRC_LIN] = 1'b0;
  end

  // (RL2) Software set acts as a hardware event
  tvic_flags u_flags (
    .ref_clk(ref_clk),
    .rst(rst),
    .src_set(src_event),
    .sw_set(sw_flag_set),
    .sw_clr(sw_clr),
    .hw_clr(hw_clr),
    .pend(pend)
  );

  // (RL6) Level first, then lowest index
  tvic_arb u_arb (
    .req(req_en),
    .lvl(lvl),
    .any(any),
    .win_high(win_high),
    .win_idx(win_idx)
  );

  // ----------------------------------------
  // Service tracking
  // ----------------------------------------
  // (RL4) Only high preempts, and only low service
  // (RL11) Equal or higher service blocks
  always_comb begin
    elig = any && !hold_r && !taken;
    unique case (svc_r)
      tvic_pkg::SVC_IDLE: elig = elig;
      tvic_pkg::SVC_LOW: elig = elig && win_high;
      tvic_pkg::SVC_HIGH: elig = 1'b0;
      tvic_pkg::SVC_HIGH_OVER_LOW: elig = 1'b0;
    endcase
  end

  always_comb begin
    svc_nxt = svc_r;
    if (taken) begin
      unique case (svc_r)
        tvic_pkg::SVC_IDLE: svc_nxt = irq_high_r ? tvic_pkg::SVC_HIGH :
                                                   tvic_pkg::SVC_LOW;
        tvic_pkg::SVC_LOW: svc_nxt = tvic_pkg::SVC_HIGH_OVER_LOW;
        tvic_pkg::SVC_HIGH: svc_nxt = svc_r;
        tvic_pkg::SVC_HIGH_OVER_LOW: svc_nxt = svc_r;
      endcase
    end else if (cpu_return_from_irq_instruction) begin
      unique case (svc_r)
        tvic_pkg::SVC_HIGH_OVER_LOW: svc_nxt = tvic_pkg::SVC_LOW;
        tvic_pkg::SVC_IDLE: svc_nxt = svc_r;
        tvic_pkg::SVC_LOW: svc_nxt = tvic_pkg::SVC_IDLE;
        tvic_pkg::SVC_HIGH: svc_nxt = tvic_pkg::SVC_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      svc_r <= tvic_pkg::SVC_IDLE;
    end else begin
      svc_r <= svc_nxt;
    end
  end

  // (RL9) One instruction must follow a return
  // (RL19) A still-set flag re-requests after it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_r <= 1'b0;
    end else if (cpu_return_from_irq_instruction) begin
      hold_r <= 1'b1;
    end else if (cpu_insn_done) begin
      hold_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // CPU request
  // ----------------------------------------
  // (RL7) Sampled and decoded every clock
  // (RL8) Request one clock after detection
  // (RL10) Only the detect clock is ours
  // (RL22) Request follows eligibility each clock until acknowledged
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_req_r <= 1'b0;
      irq_high_r <= 1'b0;
      idx_r <= '0;
    end else if (!irq_req_r || !cpu_ack) begin
      irq_req_r <= elig;
      irq_high_r <= win_high;
      idx_r <= win_idx;
    end else begin
      irq_req_r <= 1'b0;
    end
  end

  // (RL3) Vector at base plus eight per index
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_vector_r <= tvic_pkg::VEC_BASE;
    end else if (!irq_req_r || !cpu_ack) begin
      irq_vector_r <= tvic_pkg::VEC_BASE + {8'h00, win_idx, 3'b000};
    end
  end

  assign sfr_rdata = sfr_rdata_r;
  assign pend_flags = pend;
  assign irq_req = irq_req_r;
  assign irq_high = irq_high_r;
  assign irq_vector = irq_vector_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_detect;
    elig |=> irq_req_r;
  endproperty
  a_detect: assert property (p_detect) // RL8
    else $error("request not raised after detection");

  property p_vector;
    irq_req_r |-> irq_vector_r == 16'h0003 + {8'h00, idx_r, 3'b000};
  endproperty
  a_vector: assert property (p_vector) // RL3
    else $error("vector does not match winner");

  property p_gate;
    !mask_r[7] |=> !irq_req_r;
  endproperty
  a_gate: assert property (p_gate) // RL12
    else $error("request with global gate off");

  property p_lvl_rst;
    $fell(rst) |-> lvl0_r == 7'h00 && lvl1_r == 8'h00 && lvl2_r == 8'h00;
  endproperty
  a_lvl_rst: assert property (p_lvl_rst) // RL5
    else $error("level bits not zero after reset");

  property p_no_preempt;
    svc_r >= tvic_pkg::SVC_HIGH |=> !irq_req_r;
  endproperty
  a_no_preempt: assert property (p_no_preempt) // RL4
    else $error("high level service preempted");

  property p_hold;
    cpu_return_from_irq_instruction ##1 !cpu_insn_done |=> !irq_req_r;
  endproperty
  a_hold: assert property (p_hold) // RL9
    else $error("request before instruction after return");

  property p_hwclr;
    taken && tvic_pkg::HWCLR_SET[idx_r] && !src_event[idx_r] &&
      !sw_flag_set[idx_r] |=> !pend[$past(idx_r)];
  endproperty
  a_hwclr: assert property (p_hwclr) // RL21
    else $error("self-clearing flag kept after call");

  property p_lin;
    pend[14] && !lin_clr |=> pend[14];
  endproperty
  a_lin: assert property (p_lin) // RL17
    else $error("LIN flag cleared without its clear bit");

  property p_high_first;
    irq_req_r && !irq_high_r && !$past(taken) |->
      $past(~|(req_en & lvl));
  endproperty
  a_high_first: assert property (p_high_first) // RL6
    else $error("low level chosen over high");

  property p_mask_read;
    sfr_rd && sfr_addr == 8'ha8 |=> sfr_rdata_r == $past(mask_r);
  endproperty
  a_mask_read: assert property (p_mask_read) // RL15
    else $error("mask register read mismatch");

  c_call: cover property (irq_req_r ##1 taken);
  c_preempt: cover property (svc_r == tvic_pkg::SVC_HIGH_OVER_LOW);
  c_rerequest: cover property (cpu_return_from_irq_instruction ##[1:20] irq_req_r);

endmodule

// file: tvic_cpu_model.sv
`timescale 1ns/1ps
// CPU sequencer stand-in: acknowledges calls and records them
module tvic_cpu_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic ack_en,
  output logic cpu_ack,
  output logic [15:0] last_vec,
  output int n_acks
);
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_ack <= 1'b0;
      last_vec <= 16'h0000;
      n_acks <= 0;
    end else begin
      cpu_ack <= #1 irq_req && ack_en && !cpu_ack;
      if (irq_req && cpu_ack) begin
        last_vec <= irq_vector;
        n_acks <= n_acks + 1;
      end
    end
  end
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
  logic ref_clk, rst, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, irq_req;
  logic irq_high, cpu_ack, cpu_return_from_irq_instruction, cpu_insn_done, ack_en;
  logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata;
  logic [17:0] src_event, sw_flag_set, sw_flag_clr, pend_flags;
  logic t2h, t2l;
  logic [3:0] spf;
  logic [15:0] irq_vector, last_vec;
  int n_acks, checks, failures;

  tvic_top dut (.ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_addr(sfr_bit_addr),
    .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata),
    .src_event(src_event), .sw_flag_set(sw_flag_set),
    .sw_flag_clr(sw_flag_clr), .timer2_high_overflow_flag(t2h),
    .timer2_low_overflow_flag(t2l), .serial_periph_flags(spf),
    .pend_flags(pend_flags), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_high(irq_high), .cpu_ack(cpu_ack), .cpu_return_from_irq_instruction(cpu_return_from_irq_instruction),
    .cpu_insn_done(cpu_insn_done));
  tvic_cpu_model cpu (.ref_clk(ref_clk), .rst(rst), .irq_req(irq_req),
    .irq_vector(irq_vector), .ack_en(ack_en), .cpu_ack(cpu_ack),
    .last_vec(last_vec), .n_acks(n_acks));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task chk(input logic [17:0] got, input logic [17:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    clk(1);
    sfr_wr = 0;
    clk(1);
  endtask
  task bwr(input logic [7:0] ba, input logic v);
    sfr_bit_addr = ba;
    sfr_bit_val = v;
    sfr_bit_wr = 1;
    clk(1);
    sfr_bit_wr = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1;
    clk(1);
    sfr_rd = 0;
    clk(1);
    chk({10'h0, sfr_rdata}, {10'h0, e}, "read data");
  endtask
  task sset(input logic [17:0] m);
    sw_flag_set = m;
    clk(1);
    sw_flag_set = '0;
  endtask
  task sclr(input logic [17:0] m);
    sw_flag_clr = m;
    clk(1);
    sw_flag_clr = '0;
  endtask
  task return_from_irq_instruction_insn;
    cpu_return_from_irq_instruction = 1;
    clk(1);
    cpu_return_from_irq_instruction = 0;
    cpu_insn_done = 1;
    clk(1);
    cpu_insn_done = 0;
  endtask
  task wait_req(input int lim);
    int k;
    k = 0;
    while (irq_req !== 1'b1 && k < lim) begin
      clk(1);
      k++;
    end
    chk({17'h0, irq_req}, 18'h1, "request missing");
  endtask
  task wait_ack;
    int n0, k;
    n0 = n_acks;
    k = 0;
    while (n_acks == n0 && k < 10) begin
      clk(1);
      k++;
    end
    chk(18'(n_acks - n0), 18'h1, "call not taken");
  endtask
  task finish_test;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    chk(pend_flags, 18'h0, "flags after reset");
    rd(8'ha8, 8'h00);
    rd(8'hb8, 8'h80);
    rd(8'hf6, 8'h00);
    rd(8'h01, 8'h00);
  endtask
  task t_regs;
    wr(8'ha8, 8'h5a);
    rd(8'ha8, 8'h5a);
    bwr(8'haf, 1'b1);
    rd(8'ha8, 8'hda);
    wr(8'ha8, 8'h00);
  endtask
  task t_gate;
    wr(8'ha8, 8'h01);
    src_event = 18'h1;
    clk(1);
    src_event = '0;
    chk(pend_flags, 18'h1, "flag not set");
    clk(3);
    chk({17'h0, irq_req}, 18'h0, "request with gate off");
    bwr(8'haf, 1'b1);
    wait_req(3);
    sclr(18'h1);
    clk(1);
    chk({17'h0, irq_req}, 18'h0, "request after clear");
    src_event = 18'h1;
    clk(1);
    src_event = '0;
    chk({17'h0, irq_req}, 18'h0, "request too early");
    clk(1);
    chk({17'h0, irq_req}, 18'h1, "request late");
    chk({2'h0, irq_vector}, 18'h3, "ext0 vector");
    chk({17'h0, irq_high}, 18'h0, "low level after reset");
    sclr(18'h1);
  endtask
  task t_vectors;
    ack_en = 1;
    wr(8'ha8, 8'hff);
    wr(8'he6, 8'hff);
    wr(8'he7, 8'h07);
    for (int i = 0; i < 18; i++) begin
      sset(18'h1 << i);
      wait_ack;
      chk({2'h0, last_vec}, 18'(16'h0003 + 8 * i), "vector");
      clk(1);
      chk({17'h0, pend_flags[i]}, (i < 4 || i == 16) ? 18'h0 : 18'h1,
          "flag after call");
      sclr(18'h1 << i);
      if (i == 14) begin
        chk({17'h0, pend_flags[14]}, 18'h1, "lin flag cleared");
        wr(8'hc9, 8'h08);
        clk(1);
        chk({17'h0, pend_flags[14]}, 18'h0, "lin flag kept");
      end
      return_from_irq_instruction_insn;
    end
    chk(18'(n_acks), 18'h12, "call count");
  endtask
  task t_prio;
    ack_en = 0;
    sset(18'h208);
    wait_req(3);
    chk({2'h0, irq_vector}, 18'h1b, "same level order");
    wr(8'hf6, 8'h04);
    clk(2);
    chk({2'h0, irq_vector}, 18'h4b, "high level first");
    chk({17'h0, irq_high}, 18'h1, "level flag");
    sclr(18'h208);
    wr(8'hf6, 8'h00);
    clk(2);
    chk({17'h0, irq_req}, 18'h0, "request after clear");
  endtask
  task t_preempt;
    ack_en = 1;
    sset(18'h10);
    wait_ack;
    ack_en = 0;
    sclr(18'h10);
    t2l = 1;
    clk(4);
    chk({17'h0, irq_req}, 18'h0, "low over low");
    wr(8'hb8, 8'h20);
    wait_req(3);
    chk({2'h0, irq_vector}, 18'h2b, "timer2 vector");
    ack_en = 1;
    wait_ack;
    ack_en = 0;
    wr(8'hb8, 8'h60);
    spf = 4'h4;
    clk(4);
    chk({17'h0, irq_req}, 18'h0, "high preempted");
    cpu_return_from_irq_instruction = 1;
    clk(1);
    cpu_return_from_irq_instruction = 0;
    clk(3);
    chk({17'h0, irq_req}, 18'h0, "request before insn");
    cpu_insn_done = 1;
    clk(1);
    cpu_insn_done = 0;
    wait_req(3);
    chk({2'h0, irq_vector}, 18'h2b, "re-entry vector");
    t2h = 1;
    wr(8'ha8, 8'hdf);
    clk(2);
    chk({2'h0, irq_vector}, 18'h33, "timer2 masked");
    {t2h, t2l} = 2'b00;
    spf = 4'h0;
    clk(2);
    chk({17'h0, irq_req}, 18'h0, "request after drop");
    return_from_irq_instruction_insn;
  endtask

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    failures++;
    finish_test;
  end
  initial begin
    checks = 0;
    failures = 0;
    {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, t2h, t2l} = '0;
    {cpu_return_from_irq_instruction, cpu_insn_done, ack_en} = '0;
    {sfr_addr, sfr_wdata, sfr_bit_addr} = '0;
    {src_event, sw_flag_set, sw_flag_clr} = '0;
    spf = 4'h0;
    rst = 1;
    clk(20);
    rst = 0;
    t_reset;
    t_regs;
    t_gate;
    t_vectors;
    t_prio;
    t_preempt;
    finish_test;
  end
endmodule
